// file: speed_ref_pkg.sv
// speed reference shaper: offsets, fields, reset values, scaling, types
// assumes 50 MHz hclk and a 1 ms control tick
package speed_ref_pkg;
   // timing
   localparam int unsigned CLK_HZ        = 50_000_000;
   localparam int unsigned TICK_US       = 1000;  // control cycle period
   localparam int unsigned TICK_CYCLES   = CLK_HZ / 1_000_000 * TICK_US;
   localparam int unsigned TENTH_S_TICKS = 100;   // 0.1 s in ticks
   localparam int unsigned DC_FIXED_MS   = 1000;  // 1 s fixed injection
   // register byte offsets
   localparam logic [7:0] A_CTRL   = 8'h00;
   localparam logic [7:0] A_JERK   = 8'h04;
   localparam logic [7:0] A_ACCEL  = 8'h08;
   localparam logic [7:0] A_DECEL  = 8'h0C;
   localparam logic [7:0] A_LIMDEC = 8'h10;
   localparam logic [7:0] A_CURTH  = 8'h14;
   localparam logic [7:0] A_BRKDLY = 8'h18;
   localparam logic [7:0] A_SKF1   = 8'h1C;
   localparam logic [7:0] A_SKB1   = 8'h20;
   localparam logic [7:0] A_SKF2   = 8'h24;
   localparam logic [7:0] A_SKB2   = 8'h28;
   localparam logic [7:0] A_DCTIME = 8'h2C;
   localparam logic [7:0] A_REF    = 8'h30;
   localparam logic [7:0] A_STATUS = 8'h34;
   localparam logic [7:0] A_FOUT   = 8'h38;
   // control register fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_SRAMP    = 3;
   localparam int CTRL_HOLD     = 4;
   localparam int CTRL_FINV     = 5;
   localparam int CTRL_RINV     = 6;
   localparam int CTRL_REV      = 7;
   // reset values and upper limits, in register units
   localparam logic [15:0] JERK_RST   = 16'h001F;  // 3.1 in 0.1 steps
   localparam logic [15:0] ACCEL_RST  = 16'h0032;  // 5.0 s per 100 Hz
   localparam logic [15:0] LIMDEC_RST = 16'h0002;  // 0.2
   localparam logic [15:0] BRKDLY_RST = 16'h0002;  // 0.2 s
   localparam logic [15:0] SKB_RST    = 16'h0005;  // 0.5 Hz
   localparam logic [15:0] DCTIME_RST = 16'h000A;  // 1.0 s
   localparam logic [15:0] JERK_MAX   = 16'h7530;  // 3000.0
   localparam logic [15:0] LIMDEC_MAX = 16'h7D00;  // 3200.0
   localparam logic [15:0] CURTH_MAX  = 16'h03E8;  // 100.0 %
   localparam logic [15:0] BRKDLY_MAX = 16'h00FA;  // 25.0 s
   localparam logic [15:0] SKF_MAX    = 16'h2710;  // 1000.0 Hz
   localparam logic [15:0] SKB_MAX    = 16'h0032;  // 5.0 Hz
   // scaling: frequencies run internally in micro-hertz, rates per 1 ms tick
   localparam logic [31:0] HZ10_TO_UHZ    = 32'h0001_86A0;  // 0.1 Hz in uHz
   localparam logic [31:0] RATE_NUM       = 32'h000F_4240;  // uHz per tick at 0.1 s per 100 Hz
   localparam logic [31:0] JERK_NUM       = 32'h0000_03E8;  // uHz per tick^2 at 0.1 s^2/100 Hz
   localparam logic [31:0] ZERO_SPEED_UHZ = 32'h001E_8480;  // 2 Hz
   typedef enum logic [2:0] {
      stop_coast              = 3'b000,
      stop_ramp               = 3'b001,
      stop_ramp_then_dc_brake = 3'b010,
      stop_ac_then_dc_brake   = 3'b011,
      stop_timed_dc_brake     = 3'b100
   } stop_mode_t;
   typedef enum logic [2:0] {
      seq_idle      = 3'b000,
      seq_run       = 3'b001,
      seq_ramp_down = 3'b010,
      seq_ac_brake  = 3'b011,
      seq_dc_brake  = 3'b100
   } seq_state_t;
   typedef struct packed {
      logic [2:0]  mode;
      logic        sramp_en;
      logic        hold_zero;
      logic        fwd_inv;
      logic        rev_inv;
      logic        reverse;
      logic [15:0] jerk;
      logic [15:0] accel;
      logic [15:0] decel;
      logic [15:0] limdec;
      logic [15:0] curth;
      logic [15:0] brkdly;
      logic [15:0] skf1;
      logic [15:0] skb1;
      logic [15:0] skf2;
      logic [15:0] skb2;
      logic [15:0] dctime;
      logic [15:0] ref_in;
   } cfg_t;
   typedef struct packed {
      logic        bridge_en;
      logic        brake_release;
      logic        dc_inject;
      logic        ac_inject;
   } drive_out_t;
endpackage

// file: speed_reference_shaper.sv
// speed reference shaper: skip bands, ramps, limit deceleration, stop and brake sequencing
// assumes 50 MHz hclk, one AHB-Lite master, asynchronous pins
// Summary of operation
// [R01] stop mode codes: 0 coast, 1 ramp, 2 ramp+1s dc, 3 ac+1s dc, 4 timed dc
// [R02] brake status reads 0 while applied, 1 once released
// [R03] S-ramp limits jerk at ramp start and end; limit 0 to 3000.0, default 3.1
// [R04] curved section lasts jerk limit over acceleration or deceleration rate
// [R05] S-ramp adds one curved-section time, half at start, half at end
// [R06] hold-zero 0 disables bridge without run; 1 keeps it enabled holding shaft
// [R07] brake current threshold 0.0 to 100.0 percent of 150 percent full-load current
// [R08] brake release delayed 0.0 to 25.0 s, default 0.2, masking transient coincidences
// [R09] active travel limit decelerates at limit rate, 0 to 3200.0, default 0.2; larger is gentler
// [R10] forward-limit invert bit, default 0; 1 treats contact as normally closed
// [R11] two skip bands, centre 0 to 1000.0 Hz default 0, half-width 0 to 5.0 default 0.5
// [R12] a skip band with zero centre is disabled
// [R13] band spans half-width each side of centre, total twice half-width
// [R14] rising into band holds lower edge until input reaches upper edge, then follows
// [R15] falling into band jumps straight to lower edge
// [R16] S-ramp only when enable bit is 1; default 0 gives linear ramps
// [R17] current-detected is 1 above threshold, 0 below
// [R18] limit reached is raw contact xor that direction's invert bit
// [R19] skip bands applied before ramp, both evaluated every control cycle
module speed_reference_shaper
   import speed_ref_pkg::*;
#(
   parameter int unsigned TICK_DIV = TICK_CYCLES
)(
   input  wire logic                hclk,
   input  wire logic                hresetn,
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic                     hreadyout,
   output logic                     hresp,
   output logic [31:0]              hrdata,
   input  wire logic                run_pin,
   input  wire logic                healthy_pin,
   input  wire logic                fwd_limit_pin,
   input  wire logic                rev_limit_pin,
   input  wire logic [15:0]         current_mag,
   output speed_ref_pkg::drive_out_t drive_out,
   output logic [31:0]              freq_out
);
   import speed_ref_pkg::*;

   // scaled step for a time-per-span register; zero means fastest
   function automatic logic [31:0] step_of(input logic [15:0] r, input logic [31:0] num);
      step_of = (r == 16'h0000) ? num : num / {16'h0000, r};
   endfunction

   function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] mx);
      clamp16 = (v > mx) ? mx : v;
   endfunction

   // inside the open band the output sits on the lower edge
   function automatic logic [31:0] skip_band(input logic [31:0] x, input logic [15:0] c, input logic [15:0] hw);
      logic [31:0] cu;
      logic [31:0] hu;
      logic [31:0] lo;
      logic [31:0] hi;
      cu = {16'h0000, c} * HZ10_TO_UHZ;
      hu = {16'h0000, hw} * HZ10_TO_UHZ;
      lo = (cu > hu) ? cu - hu : 32'h0000_0000;  // [R13]
      hi = cu + hu;  // [R13]
      if (c == 16'h0000)
         skip_band = x;  // [R12]
      else if (x > lo && x < hi)
         skip_band = lo;  // [R14] [R15]
      else
         skip_band = x;
   endfunction

   cfg_t        cfg_r;
   cfg_t        cfg_nxt;
   seq_state_t  st_r;
   seq_state_t  st_nxt;
   logic [3:0]  sync1_r;
   logic [3:0]  sync2_r;
   logic [31:0] tick_cnt_r;
   logic        tick;
   logic        aph_wr_r;
   logic [7:0]  aph_addr_r;
   logic [31:0] rd_mux;
   logic [31:0] f_r;
   logic [31:0] a_r;
   logic [31:0] ref_skip_r;
   logic [23:0] tmr_r;
   logic [23:0] brk_cnt_r;
   logic        brake_rel_r;
   drive_out_t  out_r;

   // bus decode: single-word transfers only, zero wait states, always OKAY
   wire         aph_valid = hsel & hready & htrans[1];
   wire         wr_en     = aph_wr_r;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // pins pass two flops; only the second stage is read
   wire run_s     = sync2_r[0];
   wire healthy_s = sync2_r[1];
   wire fwd_raw   = sync2_r[2];
   wire rev_raw   = sync2_r[3];

   // limit detection, current detection, zero speed
   wire fwd_reached = fwd_raw ^ cfg_r.fwd_inv;  // [R10] [R18]
   wire rev_reached = rev_raw ^ cfg_r.rev_inv;  // [R18]
   wire lim_hit     = (st_r == seq_run) & (cfg_r.reverse ? rev_reached : fwd_reached);
   wire cur_det     = current_mag > cfg_r.curth;  // [R07] [R17]
   wire at_zero     = f_r < ZERO_SPEED_UHZ;

   // ramp target: skipped reference in run with no limit reached, else zero
   wire [31:0] ref_uhz  = {16'h0000, cfg_r.ref_in} * HZ10_TO_UHZ;
   wire [31:0] skip_1   = skip_band(ref_uhz, cfg_r.skf1, cfg_r.skb1);     // [R11]
   wire [31:0] skip_2   = skip_band(skip_1, cfg_r.skf2, cfg_r.skb2);      // [R11] [R19]
   wire [31:0] tgt      = (st_r == seq_run && !lim_hit) ? ref_skip_r : 32'h0000_0000;
   wire        up       = tgt > f_r;
   wire [31:0] err      = up ? tgt - f_r : f_r - tgt;

   // limit rate is time per span: a larger value gives a smaller step
   wire [31:0] acc_step = step_of(cfg_r.accel, RATE_NUM);
   wire [31:0] dec_step = step_of(cfg_r.decel, RATE_NUM);
   wire [31:0] lim_step = step_of(cfg_r.limdec, RATE_NUM);  // [R09]
   wire [31:0] amax     = lim_hit ? lim_step : (up ? acc_step : dec_step);
   // jerk step = amax / t with t = jerk / rate, so the rate cancels out
   wire [31:0] j_step   = step_of(cfg_r.jerk, JERK_NUM);  // [R03] [R04]
   wire        shaped   = cfg_r.sramp_en & ~lim_hit;  // [R16]

   // ease off once the distance left no longer covers the unwind
   wire [63:0] need     = {32'h0000_0000, a_r} * {32'h0000_0000, a_r + j_step};
   wire [63:0] have     = {32'h0000_0000, err} * {31'h0000_0000, j_step, 1'b0};
   wire        easing   = have <= need;
   wire [31:0] a_up     = (a_r + j_step > amax) ? amax : a_r + j_step;
   wire [31:0] a_dn     = (a_r > j_step) ? a_r - j_step : j_step;
   wire [31:0] a_shp    = (err == 32'h0000_0000) ? 32'h0000_0000 : (easing ? a_dn : a_up);  // [R03] [R05]
   wire [31:0] a_nxt    = shaped ? a_shp : amax;
   wire [31:0] mv       = (a_nxt > err) ? err : a_nxt;
   wire        f_zeroed = (st_r == seq_idle) | (st_r == seq_dc_brake);
   wire [31:0] f_nxt    = f_zeroed ? 32'h0000_0000 : (up ? f_r + mv : f_r - mv);

   // brake release condition and its delay in ticks
   wire        brk_cond  = healthy_s & cur_det & ~at_zero & (st_r == seq_run);
   wire [23:0] brk_limit = 24'(cfg_r.brkdly * 16'(TENTH_S_TICKS));
   wire [23:0] dc_load   = (cfg_r.mode == stop_timed_dc_brake) ? 24'(cfg_r.dctime * 16'(TENTH_S_TICKS))
                                                              : 24'(DC_FIXED_MS);

   // stop sequencer
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         seq_idle: begin
            if (run_s) st_nxt = seq_run;
         end
         seq_run: begin
            if (!run_s) begin
               unique case (cfg_r.mode)  // [R01]
                  stop_coast:              st_nxt = seq_idle;
                  stop_ramp:               st_nxt = seq_ramp_down;
                  stop_ramp_then_dc_brake: st_nxt = seq_ramp_down;
                  stop_ac_then_dc_brake:   st_nxt = seq_ac_brake;
                  stop_timed_dc_brake:     st_nxt = seq_dc_brake;
                  default:                 st_nxt = seq_idle;
               endcase
            end
         end
         seq_ramp_down: begin
            if (run_s)
               st_nxt = seq_run;
            else if (f_r == 32'h0000_0000)
               st_nxt = (cfg_r.mode == stop_ramp_then_dc_brake) ? seq_dc_brake : seq_idle;  // [R01]
         end
         seq_ac_brake: begin
            if (run_s)
               st_nxt = seq_run;
            else if (f_r == 32'h0000_0000)
               st_nxt = seq_dc_brake;  // [R01]
         end
         seq_dc_brake: begin
            if (run_s)
               st_nxt = seq_run;
            else if (tmr_r == 24'h00_0000)
               st_nxt = seq_idle;
         end
         default: st_nxt = seq_idle;
      endcase
   end

   // register writes, clamped to each setting's range except accel, decel and dctime, which are stored unclamped
   always_comb begin
      cfg_nxt = cfg_r;
      if (wr_en) begin
         unique case (aph_addr_r)
            A_CTRL: begin
               if (hwdata[CTRL_MODE_LSB +: 3] <= stop_timed_dc_brake)
                  cfg_nxt.mode = hwdata[CTRL_MODE_LSB +: 3];
               cfg_nxt.sramp_en  = hwdata[CTRL_SRAMP];
               cfg_nxt.hold_zero = hwdata[CTRL_HOLD];
               cfg_nxt.fwd_inv   = hwdata[CTRL_FINV];
               cfg_nxt.rev_inv   = hwdata[CTRL_RINV];
               cfg_nxt.reverse   = hwdata[CTRL_REV];
            end
            A_JERK:   cfg_nxt.jerk   = clamp16(hwdata[15:0], JERK_MAX);  // [R03]
            A_ACCEL:  cfg_nxt.accel  = hwdata[15:0];
            A_DECEL:  cfg_nxt.decel  = hwdata[15:0];
            A_LIMDEC: cfg_nxt.limdec = clamp16(hwdata[15:0], LIMDEC_MAX); // [R09]
            A_CURTH:  cfg_nxt.curth  = clamp16(hwdata[15:0], CURTH_MAX);  // [R07]
            A_BRKDLY: cfg_nxt.brkdly = clamp16(hwdata[15:0], BRKDLY_MAX); // [R08]
            A_SKF1:   cfg_nxt.skf1   = clamp16(hwdata[15:0], SKF_MAX);    // [R11]
            A_SKB1:   cfg_nxt.skb1   = clamp16(hwdata[15:0], SKB_MAX);    // [R11]
            A_SKF2:   cfg_nxt.skf2   = clamp16(hwdata[15:0], SKF_MAX);    // [R11]
            A_SKB2:   cfg_nxt.skb2   = clamp16(hwdata[15:0], SKB_MAX);    // [R11]
            A_DCTIME: cfg_nxt.dctime = hwdata[15:0];
            A_REF:    cfg_nxt.ref_in = clamp16(hwdata[15:0], SKF_MAX);
            default:  cfg_nxt = cfg_r;  // unmapped or read-only
         endcase
      end
   end

   // read mux, sampled at the address phase so hrdata comes from a flop
   always_comb begin
      unique case (haddr[7:0])
         A_CTRL:   rd_mux = {24'h00_0000, cfg_r.reverse, cfg_r.rev_inv, cfg_r.fwd_inv,
                             cfg_r.hold_zero, cfg_r.sramp_en, cfg_r.mode};
         A_JERK:   rd_mux = {16'h0000, cfg_r.jerk};
         A_ACCEL:  rd_mux = {16'h0000, cfg_r.accel};
         A_DECEL:  rd_mux = {16'h0000, cfg_r.decel};
         A_LIMDEC: rd_mux = {16'h0000, cfg_r.limdec};
         A_CURTH:  rd_mux = {16'h0000, cfg_r.curth};
         A_BRKDLY: rd_mux = {16'h0000, cfg_r.brkdly};
         A_SKF1:   rd_mux = {16'h0000, cfg_r.skf1};
         A_SKB1:   rd_mux = {16'h0000, cfg_r.skb1};
         A_SKF2:   rd_mux = {16'h0000, cfg_r.skf2};
         A_SKB2:   rd_mux = {16'h0000, cfg_r.skb2};
         A_DCTIME: rd_mux = {16'h0000, cfg_r.dctime};
         A_REF:    rd_mux = {16'h0000, cfg_r.ref_in};
         A_STATUS: rd_mux = {21'h00_0000, st_r, out_r.ac_inject, out_r.dc_inject, at_zero,
                             rev_reached, fwd_reached, out_r.bridge_en, cur_det, brake_rel_r};  // [R02]
         A_FOUT:   rd_mux = f_r;
         default:  rd_mux = 32'h0000_0000;
      endcase
   end

   // bus address phase and read data
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         aph_wr_r   <= 1'b0;
         aph_addr_r <= 8'h00;
         hrdata     <= 32'h0000_0000;
      end else begin
         aph_wr_r   <= aph_valid & hwrite;
         aph_addr_r <= haddr[7:0];
         if (aph_valid && !hwrite) hrdata <= rd_mux;
      end
   end

   // settings
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_r <= '{mode: stop_ramp, jerk: JERK_RST, accel: ACCEL_RST, decel: ACCEL_RST,
                    limdec: LIMDEC_RST, brkdly: BRKDLY_RST, skb1: SKB_RST, skb2: SKB_RST,
                    dctime: DCTIME_RST,
                    default: '0};  // [R10] [R16]
      end else begin
         cfg_r <= cfg_nxt;
      end
   end

   // pin synchronisers and control tick divider
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_r    <= 4'h0;
         sync2_r    <= 4'h0;
         tick_cnt_r <= 32'h0000_0000;
      end else begin
         sync1_r    <= {rev_limit_pin, fwd_limit_pin, healthy_pin, run_pin};
         sync2_r    <= sync1_r;
         tick_cnt_r <= (tick_cnt_r == TICK_DIV - 1) ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
      end
   end
   assign tick = (tick_cnt_r == TICK_DIV - 1);

   // state moves at once; ramp, skip and timers advance on the tick
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r       <= seq_idle;
         f_r        <= 32'h0000_0000;
         a_r        <= 32'h0000_0000;
         ref_skip_r <= 32'h0000_0000;
         tmr_r      <= 24'h00_0000;
      end else begin
         st_r <= st_nxt;
         if (st_nxt == seq_dc_brake && st_r != seq_dc_brake)
            tmr_r <= dc_load;  // [R01]
         else if (tick && tmr_r != 24'h00_0000)
            tmr_r <= tmr_r - 24'h00_0001;
         if (tick) begin
            ref_skip_r <= skip_2;  // [R19]
            f_r        <= f_nxt;
            a_r        <= f_zeroed ? 32'h0000_0000 : a_nxt;
         end
         if (st_nxt == seq_idle && st_r == seq_run) begin
            f_r <= 32'h0000_0000;  // coast: output drops at once
            a_r <= 32'h0000_0000;
         end
      end
   end

   // brake release: condition must hold for the whole delay; any break applies the brake
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         brk_cnt_r   <= 24'h00_0000;
         brake_rel_r <= 1'b0;
      end else begin
         if (!brk_cond) begin
            brk_cnt_r   <= 24'h00_0000;
            brake_rel_r <= 1'b0;  // [R02]
         end else if (tick) begin
            if (brk_cnt_r >= brk_limit)
               brake_rel_r <= 1'b1;  // [R08] [R02]
            else
               brk_cnt_r <= brk_cnt_r + 24'h00_0001;
         end
      end
   end

   // drive outputs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_r <= '0;
      end else begin
         out_r.bridge_en     <= (st_nxt != seq_idle) | cfg_r.hold_zero;  // [R06]
         out_r.dc_inject     <= (st_nxt == seq_dc_brake);
         out_r.ac_inject     <= (st_nxt == seq_ac_brake);
         out_r.brake_release <= brake_rel_r;
      end
   end
   assign drive_out = out_r;
   assign freq_out  = f_r;
endmodule // speed_reference_shaper

// file: speed_ref_monitor.sv
// checker: injection, brake and frequency outputs
// assumes hresetn asynchronous, active low
module speed_ref_monitor
#(
   parameter int unsigned TICK_DIV = speed_ref_pkg::TICK_CYCLES
)(
   input wire logic                      hclk,
   input wire logic                      hresetn,
   input wire logic                      run_pin,
   input wire logic                      healthy_pin,
   input wire logic [15:0]               current_mag,
   input wire speed_ref_pkg::drive_out_t drive_out,
   input wire logic [31:0]               freq_out
);
   import speed_ref_pkg::*;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic [31:0] prev_r;
   int unsigned since_r;
   wire         step_seen = (freq_out != prev_r) && (freq_out != 32'h0) && (prev_r != 32'h0);
   // cycles since the last running step; a coast to zero may land off the tick
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prev_r  <= 32'h0;
         since_r <= 0;
      end else begin
         prev_r  <= freq_out;
         since_r <= step_seen ? 0 : since_r + 1;
      end
   end
   sequence s_brake_rise;
      !drive_out.brake_release ##1 drive_out.brake_release;
   endsequence
   inject_exclusive_a: assert property (!(drive_out.dc_inject && drive_out.ac_inject))
      else $error("dc and ac injection both on");
   inject_bridge_a: assert property (drive_out.dc_inject || drive_out.ac_inject |-> drive_out.bridge_en)
      else $error("injection without bridge");
   brake_gate_a: assert property (s_brake_rise |-> $past(run_pin, 5) && $past(healthy_pin, 5))
      else $error("brake released without run and healthy");
   brake_current_a: assert property (drive_out.brake_release |-> $past(current_mag, 2) != 16'h0)
      else $error("brake released with no current");
   brake_speed_a: assert property (drive_out.brake_release |-> $past(freq_out, 3) != 32'h0)
      else $error("brake released at zero speed");
   freq_step_a: assert property (freq_out > $past(freq_out) |-> freq_out - $past(freq_out) <= RATE_NUM)
      else $error("frequency step too large");
   tick_pace_a: assert property (step_seen |-> since_r >= TICK_DIV - 1)
      else $error("frequency stepped between ticks");
   bridge_freq_a: assert property (freq_out != 32'h0 && $past(freq_out) != 32'h0 |-> drive_out.bridge_en)
      else $error("running frequency with bridge off");
endmodule // speed_ref_monitor
bind speed_reference_shaper speed_ref_monitor #(.TICK_DIV(TICK_DIV)) u_speed_ref_monitor (.hclk(hclk),
   .hresetn(hresetn), .run_pin(run_pin), .healthy_pin(healthy_pin), .current_mag(current_mag),
   .drive_out(drive_out), .freq_out(freq_out));

// file: speed_ref_partner.sv
// far side: bridge current, drive health, limit contacts
// assumes bench-driven trip, load and contacts
module speed_ref_partner
(
   input  wire logic                      hclk,
   input  wire logic                      hresetn,
   input  wire speed_ref_pkg::drive_out_t drive_out,
   input  wire logic                      trip,
   input  wire logic [15:0]               load,
   input  wire logic                      fwd_hit,
   input  wire logic                      rev_hit,
   input  wire logic                      fwd_nc,
   input  wire logic                      rev_nc,
   output logic                           healthy_pin,
   output logic                           fwd_limit_pin,
   output logic                           rev_limit_pin,
   output logic [15:0]                    current_mag
);
   import speed_ref_pkg::*;
   // a normally closed contact opens when its limit is hit
   assign fwd_limit_pin = fwd_hit ^ fwd_nc;
   assign rev_limit_pin = rev_hit ^ rev_nc;
   assign healthy_pin   = !trip;
   // current flows while the bridge is on, one cycle late
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         current_mag <= 16'h0000;
      else
         current_mag <= drive_out.bridge_en ? load : 16'h0000;
   end
endmodule // speed_ref_partner

// file: speed_reference_shaper_test.sv
// bench: registers, stop modes, brake, hold, skip bands, limits
// assumes a control tick shortened to TD clocks
module speed_reference_shaper_test;
   timeunit 1ns;
   timeprecision 1ns;
   import speed_ref_pkg::*;
   localparam int unsigned TD = 20;
   logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, run_pin = 1'h0;
   logic        fwd_hit = 1'h0, fwd_nc = 1'h0, hreadyout, hresp, healthy_pin, fwd_limit_pin, rev_limit_pin;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, freq_out, rd;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [15:0] current_mag;
   drive_out_t  drive_out;
   int          err_total = 0, cmp_count = 0, cyc = 0;
   int          rt[8][3] = '{'{8'h04, 16'h1F, 16'h7530}, '{8'h10, 16'h2, 16'h7D00}, '{8'h14, 16'h0, 16'h3E8},
      '{8'h18, 16'h2, 16'hFA}, '{8'h1C, 16'h0, 16'h2710}, '{8'h20, 16'h5, 16'h32},
      '{8'h24, 16'h0, 16'h2710}, '{8'h28, 16'h5, 16'h32}};
   int          sk[6][4] = '{'{8'h1C, 100, 20, 105}, '{8'h1C, 100, 20, 130}, '{8'h1C, 100, 20, 95},
      '{8'h1C, 0, 20, 95}, '{8'h24, 300, 10, 295}, '{8'h24, 300, 10, 310}};
   always #10 hclk = ~hclk;
   speed_reference_shaper #(.TICK_DIV(TD)) u_speed_reference_shaper (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .run_pin(run_pin), .healthy_pin(healthy_pin),
      .fwd_limit_pin(fwd_limit_pin), .rev_limit_pin(rev_limit_pin), .current_mag(current_mag),
      .drive_out(drive_out), .freq_out(freq_out));
   speed_ref_partner u_speed_ref_partner (.hclk(hclk), .hresetn(hresetn), .drive_out(drive_out), .trip(1'h0),
      .load(16'h01F4), .fwd_hit(fwd_hit), .rev_hit(1'h0), .fwd_nc(fwd_nc), .rev_nc(1'h0),
      .healthy_pin(healthy_pin), .fwd_limit_pin(fwd_limit_pin), .rev_limit_pin(rev_limit_pin),
      .current_mag(current_mag));
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // timeout ceiling
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         err_total++;
         close_out();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one word: each phase held until hready, read taken there
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'h1;
      haddr  <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      hsel   <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      rd = hrdata;
   endtask
   function automatic logic [31:0] clampv(input int v, input int m);
      return (v > m) ? m : v;
   endfunction
   // open band gives the lower edge; zero centre disables
   function automatic logic [31:0] skip_exp(input int f, input int b, input int r);
      return ((f != 0 && r > f - b && r < f + b) ? f - b : r) * HZ10_TO_UHZ;
   endfunction
   task automatic skip_case(input logic [7:0] a, input int f, input int b, input int r);
      xfer(1'h1, a, f);
      xfer(1'h1, a + 8'h04, b);
      xfer(1'h1, A_REF, r);
      repeat (45 * TD) @(posedge hclk);
      chk(freq_out, skip_exp(f, b, r));
   endtask
   initial begin
      int v, n, m, dc, ac;
      void'($urandom(32'hE1A3));
      repeat (2) @(posedge hclk);
      hresetn <= 1'h1;
      // reset value, random, top corner, reset value
      xfer(1'h0, A_CTRL, 32'h0);
      chk(rd, 32'h1);
      for (int i = 0; i < 8; i++) begin
         xfer(1'h0, rt[i][0], 32'h0);
         chk(rd, rt[i][1]);
         for (n = 0; n < 3; n++) begin
            v = (n == 0) ? $urandom_range(16'hFFFF) : (n == 1) ? 16'hFFFF : rt[i][1];
            xfer(1'h1, rt[i][0], v);
            xfer(1'h0, rt[i][0], 32'h0);
            chk(rd, clampv(v, rt[i][2]));
         end
      end
      xfer(1'h1, 8'h3C, 32'hFFFF);
      xfer(1'h0, 8'h3C, 32'h0);
      chk(rd, 32'h0);
      xfer(1'h1, A_ACCEL, 32'h1);
      xfer(1'h1, A_DECEL, 32'h1);
      xfer(1'h1, A_BRKDLY, 32'h1);
      xfer(1'h1, A_DCTIME, 32'h1);
      xfer(1'h1, A_REF, 32'h64);
      // each stop mode: run to 10 Hz, then stop
      for (m = 0; m < 5; m++) begin
         xfer(1'h1, A_CTRL, m);
         run_pin <= 1'h1;
         repeat (150 * TD) @(posedge hclk);
         chk(freq_out, 32'h0098_9680);
         chk(drive_out.brake_release, 1'h1);
         xfer(1'h0, A_STATUS, 32'h0);
         chk(rd[0], 1'h1);
         run_pin <= 1'h0;
         dc = 0;
         ac = 0;
         for (n = 0; n < 25000 && (n < 9 || drive_out.bridge_en || freq_out != 0); n++) begin
            @(posedge hclk);
            dc += drive_out.dc_inject;
            ac += drive_out.ac_inject;
         end
         chk((dc + TD / 2) / TD, (m == 2 || m == 3) ? DC_FIXED_MS : (m == 4) ? TENTH_S_TICKS : 0);
         chk(ac != 0, m == 3);
         if (m == 0)
            chk(n, 9);
      end
      xfer(1'h1, A_CTRL, 32'h10);
      repeat (8) @(posedge hclk);
      chk(drive_out.bridge_en, 1'h1);
      xfer(1'h1, A_CTRL, 32'h0);
      run_pin <= 1'h1;
      for (int i = 0; i < 6; i++)
         skip_case(sk[i][0], sk[i][1], sk[i][2], sk[i][3]);
      for (n = 0; n < 3; n++)
         skip_case(A_SKF2, 300, 10, $urandom_range(400));
      // forward limit, open then closed contact
      xfer(1'h1, A_REF, 32'h64);
      for (m = 0; m < 2; m++) begin
         xfer(1'h1, A_CTRL, m << CTRL_FINV);
         fwd_nc <= m;
         repeat (45 * TD) @(posedge hclk);
         chk(freq_out, 32'h0098_9680);
         fwd_hit <= 1'h1;
         repeat (25 * TD) @(posedge hclk);
         chk(freq_out, 32'h0);
         fwd_hit <= 1'h0;
      end
      run_pin <= 1'h0;
      close_out();
   end
endmodule // speed_reference_shaper_test
